// *** tcc_capcomp.sv ***
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Trigger from pin, or comparator when selected
// - Inputs synchronized; filter adds four cycles
// - Filter and edge input frozen in capture-top modes
// - Filter output changes after four equal samples
// - Filter enable bit; runs on system clock
// - Each capture overwrites the capture value
// - Edge detector sees pin including own drive
// - Compare flag requests irq; ack or write-one clears
// - Compare double buffered in PWM modes only
// - CPU reaches buffer or register; reads bypass latch
// - High byte first; low write commits 16 bits
// - Force applies action outside PWM modes; no flag, no counter
// - Counter write blocks matches next timer tick
// - Output latch kept across mode changes
// - Action field unbuffered; force acts immediately
// - Reset clears output latch
// - Nonzero action overrides port data; direction drives
// - Action zero leaves latch untouched
// - Capture copies counter and sets flag together
// - Capture flag requests irq; ack or write-one clears
module tcc_capcomp (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Counter unit
   input  wire logic        timer_tick,
   input  wire logic [15:0] counter_value,
   input  wire logic        counter_write,
   input  wire logic        counter_top,
   input  wire logic        counter_bottom,
   input  wire logic [3:0]  waveform_mode_select,
   // Capture sources
   input  wire logic        capture_input_pin,
   input  wire logic        comparator_output,
   // Interrupts
   input  wire logic [2:0]  irq_ack,
   output logic      [2:0]  irq_req,
   // Compare output pins
   input  wire logic [1:0]  port_data,
   input  wire logic [1:0]  output_pin_direction_bit,
   output logic      [1:0]  compare_pin_o,
   output logic      [1:0]  compare_pin_oe
);

   // ----------------------------------------------------------------
   // Mode decoding
   // ----------------------------------------------------------------
   function automatic logic mode_is_pwm(input logic [3:0] m);
      mode_is_pwm = !(m == 4'h0 || m == 4'h4 || m == 4'hc || m == 4'hd);
   endfunction

   function automatic logic mode_cap_top(input logic [3:0] m);
      mode_cap_top = (m == 4'h8 || m == 4'ha || m == 4'hc || m == 4'he);
   endfunction

   function automatic logic mode_upd_top(input logic [3:0] m);
      mode_upd_top = (m == 4'h1 || m == 4'h2 || m == 4'h3 ||
                      m == 4'ha || m == 4'hb);
   endfunction

   // New latch value for an action
   function automatic logic apply_action(input logic [1:0] act,
                                         input logic       cur);
      case (act)
         tcc_pkg::ACT_TOGGLE: apply_action = ~cur;
         tcc_pkg::ACT_CLEAR:  apply_action = 1'b0;
         tcc_pkg::ACT_SET:    apply_action = 1'b1;
         default:             apply_action = cur;
      endcase
   endfunction

   // Compare value as the CPU sees it: buffer when buffering is active
   function automatic logic [15:0] cmp_view(input logic        buffered,
                                            input logic [15:0] buf_val,
                                            input logic [15:0] live_val);
      if (buffered) begin
         cmp_view = buf_val;
      end else begin
         cmp_view = live_val;
      end
   endfunction

   // ----------------------------------------------------------------
   // State and helper values
   // ----------------------------------------------------------------
   tcc_pkg::tcc_state_t st_q;
   tcc_pkg::tcc_state_t st_d;

   logic                            pwm;
   logic                            frozen;
   logic                            cap_src;
   logic [tcc_pkg::FILTER_LEN-1:0]  filt_win;
   logic                            edge_in;
   logic                            cap_evt;
   logic                            xfer;
   logic [1:0]                      hit;
   logic [1:0]                      force_cmp;
   logic [15:0]                     wr_word;
   logic [15:0]                     view_a;
   logic [15:0]                     view_b;
   logic [2:0]                      hw_set;
   logic [2:0]                      sw_clr;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      st_d      = st_q;
      pwm       = mode_is_pwm(waveform_mode_select);
      frozen    = mode_cap_top(waveform_mode_select);
      cap_src   = 1'b0;
      filt_win  = '0;
      edge_in   = 1'b0;
      cap_evt   = 1'b0;
      xfer      = 1'b0;
      hit       = 2'h0;
      force_cmp = 2'h0;
      wr_word   = {st_q.temp, reg_wdata};
      view_a    = cmp_view(pwm, st_q.cmp_buf[0], st_q.cmp[0]);
      view_b    = cmp_view(pwm, st_q.cmp_buf[1], st_q.cmp[1]);
      hw_set    = 3'h0;
      sw_clr    = 3'h0;

      // Two flip-flops on each asynchronous source. The pin is taken as
      // it stands, so driving it from the port also triggers a capture.
      st_d.cap_sync1  = capture_input_pin;
      st_d.cap_sync2  = st_q.cap_sync1;
      st_d.acmp_sync1 = comparator_output;
      st_d.acmp_sync2 = st_q.acmp_sync1;

      // Trigger source
      if (st_q.acmp_sel) begin
         cap_src = st_q.acmp_sync2;
      end else begin
         cap_src = st_q.cap_sync2;
      end

      // Noise filter on every system clock outside capture-top modes; the window holds the newest
      // sample and the three before it
      filt_win = {st_q.filt_sh[tcc_pkg::FILTER_LEN-2:0], cap_src};
      if (!frozen) begin
         st_d.filt_sh = filt_win;
         if (&filt_win) begin
            st_d.filt_out = 1'b1;
         end else if (~|filt_win) begin
            st_d.filt_out = 1'b0;
         end
      end

      // Edge detector, fed by the filter when it is enabled
      if (st_q.filter_en) begin
         edge_in = st_q.filt_out;
      end else begin
         edge_in = cap_src;
      end
      if (!frozen) begin
         st_d.edge_prev = edge_in;
         if (st_q.edge_rising) begin
            cap_evt = edge_in & ~st_q.edge_prev;
         end else begin
            cap_evt = ~edge_in & st_q.edge_prev;
         end
      end

      // Capture: a new event always overwrites the old value
      if (cap_evt) begin
         st_d.cap_val              = counter_value;
         hw_set[tcc_pkg::FLAG_CAP] = 1'b1;
      end

      // A counter write blocks matches up to and including the next tick
      if (counter_write) begin
         st_d.block = 1'b1;
      end else if (timer_tick) begin
         st_d.block = 1'b0;
      end

      // Compare matches act on the tick; the flag is up one cycle later
      for (int i = 0; i < 2; i++) begin
         hit[i] = timer_tick && !st_q.block && !counter_write &&
                  (counter_value == st_q.cmp[i]);
         if (hit[i]) begin
            hw_set[tcc_pkg::FLAG_CMPA + i] = 1'b1;
            st_d.latch[i] = apply_action(st_q.action[i],
                                         st_q.latch[i]);
         end
      end

      // Buffer to compare register at the selected end of the count
      if (mode_upd_top(waveform_mode_select)) begin
         xfer = timer_tick && counter_top;
      end else begin
         xfer = timer_tick && counter_bottom;
      end
      if (pwm && xfer) begin
         st_d.cmp = st_q.cmp_buf;
      end

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            tcc_pkg::ADDR_CTRL_B: begin
               st_d.filter_en   = reg_wdata[tcc_pkg::CTRL_B_FILTER_BIT];
               st_d.edge_rising = reg_wdata[tcc_pkg::CTRL_B_EDGE_BIT];
            end
            tcc_pkg::ADDR_CMP_CTRL: begin
               st_d.action[0] = reg_wdata[tcc_pkg::CMP_ACT_A_LSB +: 2];
               st_d.action[1] = reg_wdata[tcc_pkg::CMP_ACT_B_LSB +: 2];
               force_cmp[0]   = reg_wdata[tcc_pkg::CMP_FORCE_A_BIT] & !pwm;
               force_cmp[1]   = reg_wdata[tcc_pkg::CMP_FORCE_B_BIT] & !pwm;
            end
            tcc_pkg::ADDR_IRQ_EN: begin
               st_d.irq_en = reg_wdata[2:0];
            end
            tcc_pkg::ADDR_FLAGS: begin
               sw_clr = reg_wdata[2:0];
            end
            tcc_pkg::ADDR_ACMP_CTRL: begin
               st_d.acmp_sel = reg_wdata[tcc_pkg::ACMP_SEL_BIT];
            end
            tcc_pkg::ADDR_CMPA_HI, tcc_pkg::ADDR_CMPB_HI: begin
               st_d.temp = reg_wdata;
            end
            tcc_pkg::ADDR_CMPA_LO: begin
               st_d.cmp_buf[0] = wr_word;
               if (!pwm) begin
                  st_d.cmp[0] = wr_word;
               end
            end
            tcc_pkg::ADDR_CMPB_LO: begin
               st_d.cmp_buf[1] = wr_word;
               if (!pwm) begin
                  st_d.cmp[1] = wr_word;
               end
            end
            default: begin
            end
         endcase
      end

      // Register reads; data stand for the one cycle after the strobe.
      // The compare registers are read directly, never through temp.
      st_d.rdata = tcc_pkg::RD_UNMAPPED;
      if (reg_rd) begin
         case (reg_addr)
            tcc_pkg::ADDR_CTRL_B: begin
               st_d.rdata = {st_q.filter_en, st_q.edge_rising, 6'h00};
            end
            tcc_pkg::ADDR_CMP_CTRL: begin
               st_d.rdata = {st_q.action[0], st_q.action[1], 4'h0};
            end
            tcc_pkg::ADDR_IRQ_EN: begin
               st_d.rdata = {5'h00, st_q.irq_en};
            end
            tcc_pkg::ADDR_FLAGS: begin
               st_d.rdata = {5'h00, st_q.flags};
            end
            tcc_pkg::ADDR_ACMP_CTRL: begin
               st_d.rdata = {7'h00, st_q.acmp_sel};
            end
            tcc_pkg::ADDR_CAP_LO: begin
               st_d.rdata = st_q.cap_val[7:0];
               st_d.temp  = st_q.cap_val[15:8];
            end
            tcc_pkg::ADDR_CAP_HI: begin
               st_d.rdata = st_q.temp;
            end
            tcc_pkg::ADDR_CMPA_LO: begin
               st_d.rdata = view_a[7:0];
            end
            tcc_pkg::ADDR_CMPA_HI: begin
               st_d.rdata = view_a[15:8];
            end
            tcc_pkg::ADDR_CMPB_LO: begin
               st_d.rdata = view_b[7:0];
            end
            tcc_pkg::ADDR_CMPB_HI: begin
               st_d.rdata = view_b[15:8];
            end
            default: begin
               st_d.rdata = tcc_pkg::RD_UNMAPPED;
            end
         endcase
      end

      // Flags: acknowledge or write-one clears, a set in the same cycle
      // wins
      sw_clr     = sw_clr | irq_ack;
      st_d.flags = (st_q.flags & ~sw_clr) | hw_set;
      st_d.irq   = st_d.flags & st_d.irq_en;

      // Force acts with the action just written, sets no flag and leaves
      // the counter alone
      for (int i = 0; i < 2; i++) begin
         if (force_cmp[i]) begin
            st_d.latch[i] = apply_action(st_d.action[i],
                                         st_d.latch[i]);
         end
      end

      // Pin: latch replaces port data once an action is set; the
      // direction bit alone decides whether the pin drives. Mode changes
      // never touch the latch.
      for (int i = 0; i < 2; i++) begin
         if (st_d.action[i] != tcc_pkg::ACT_NONE) begin
            st_d.pin_o[i] = st_d.latch[i];
         end else begin
            st_d.pin_o[i] = port_data[i];
         end
      end
      st_d.pin_oe = output_pin_direction_bit;

      // Synchronous reset clears everything, the output latch included;
      // the pin follows the port straight away
      if (sys_rst) begin
         st_d        = '0;
         st_d.pin_o  = port_data;
         st_d.pin_oe = output_pin_direction_bit;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      st_q <= st_d;
   end

   // ----------------------------------------------------------------
   // Outputs, each straight from the state register
   // ----------------------------------------------------------------
   assign reg_rdata      = st_q.rdata;
   assign irq_req        = st_q.irq;
   assign compare_pin_o  = st_q.pin_o;
   assign compare_pin_oe = st_q.pin_oe;

endmodule // tcc_capcomp
`default_nettype wire

// *** tcc_pkg.sv ***
`default_nettype none
package tcc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL_B    = 4'h0;
   localparam logic [3:0] ADDR_CMP_CTRL  = 4'h1;
   localparam logic [3:0] ADDR_IRQ_EN    = 4'h2;
   localparam logic [3:0] ADDR_FLAGS     = 4'h3;
   localparam logic [3:0] ADDR_ACMP_CTRL = 4'h4;
   localparam logic [3:0] ADDR_CAP_LO    = 4'h5;
   localparam logic [3:0] ADDR_CAP_HI    = 4'h6;
   localparam logic [3:0] ADDR_CMPA_LO   = 4'h7;
   localparam logic [3:0] ADDR_CMPA_HI   = 4'h8;
   localparam logic [3:0] ADDR_CMPB_LO   = 4'h9;
   localparam logic [3:0] ADDR_CMPB_HI   = 4'ha;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_B_FILTER_BIT = 7;
   localparam int CTRL_B_EDGE_BIT   = 6;
   localparam int CMP_ACT_A_LSB     = 6;
   localparam int CMP_ACT_B_LSB     = 4;
   localparam int CMP_FORCE_A_BIT   = 3;
   localparam int CMP_FORCE_B_BIT   = 2;
   localparam int ACMP_SEL_BIT      = 0;
   localparam int FLAG_CAP          = 0;
   localparam int FLAG_CMPA         = 1;
   localparam int FLAG_CMPB         = 2;

   // ----------------------------------------------------------------
   // Encodings and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;
   localparam int         FILTER_LEN = 4;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   typedef struct packed {
      logic                   cap_sync1;
      logic                   cap_sync2;
      logic                   acmp_sync1;
      logic                   acmp_sync2;
      logic [FILTER_LEN-1:0]  filt_sh;
      logic                   filt_out;
      logic                   edge_prev;
      logic                   filter_en;
      logic                   edge_rising;
      logic                   acmp_sel;
      logic [1:0][1:0]        action;
      logic [2:0]             irq_en;
      logic [2:0]             flags;
      logic [15:0]            cap_val;
      logic [7:0]             temp;
      logic [1:0][15:0]       cmp;
      logic [1:0][15:0]       cmp_buf;
      logic [1:0]             latch;
      logic                   block;
      logic [7:0]             rdata;
      logic [2:0]             irq;
      logic [1:0]             pin_o;
      logic [1:0]             pin_oe;
   } tcc_state_t;

endpackage
`default_nettype wire

// *** tcc_capcomp_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module tcc_chk (
   input wire logic       ref_clk, sys_rst, timer_tick,
   input wire logic [2:0] irq_ack, irq_req,
   input wire logic [1:0] port_data, output_pin_direction_bit,
   input wire logic [1:0] compare_pin_o, compare_pin_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_tk; $past(timer_tick) || $past(timer_tick, 2); endsequence
   a_oe_dir: assert property (compare_pin_oe ==
      $past(output_pin_direction_bit)) else $error("pin enable");
   a_rst_irq: assert property (disable iff (1'b0)
      sys_rst |=> irq_req == 3'h0) else $error("irq after reset");
   a_rst_pin: assert property (disable iff (1'b0)
      sys_rst |=> compare_pin_o == $past(port_data)) else $error("pin");
   a_ack_cap: assert property (irq_ack[0] |=> !irq_req[0])
      else $error("capture ack");
   a_ack_cmpa: assert property (irq_ack[1] |=> !irq_req[1])
      else $error("compare a ack");
   a_ack_cmpb: assert property (irq_ack[2] |=> !irq_req[2])
      else $error("compare b ack");
   a_cmpa_tick: assert property ($rose(irq_req[1]) |-> s_tk)
      else $error("compare a without tick");
   a_cmpb_tick: assert property ($rose(irq_req[2]) |-> s_tk)
      else $error("compare b without tick");
endmodule // tcc_chk
bind tcc_capcomp tcc_chk i_chk (.*);
`default_nettype wire

// *** tcc_ext.sv ***
`timescale 1ns/100ps
`default_nettype none
module tcc_ext (
   input  wire logic ref_clk,
   input  wire logic lvl,
   output logic      capture_input_pin
);
   always_ff @(posedge ref_clk) capture_input_pin <= lvl;
endmodule // tcc_ext
`default_nettype wire

// *** tcc_capcomp_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tcc_capcomp_tb;
   logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, tick = 0;
   logic lvl = 0, acmp = 0, pin, cw = 0, ctop = 0;
   logic [3:0] addr = 0, mode = 0;
   logic [7:0] wd = 0, rd;
   logic [15:0] cnt = 0;
   logic [2:0] ack = 0, irq;
   logic [1:0] pd = 2'h2, dir = 0, po, poe;
   int n_mismatch = 0, n_tests = 0;
   always #4 ref_clk = ~ref_clk;
   tcc_ext i_ext (.ref_clk, .lvl, .capture_input_pin(pin));
   tcc_capcomp i_dut (.ref_clk, .sys_rst, .reg_addr(addr), .reg_wdata(wd),
      .reg_wr, .reg_rd, .reg_rdata(rd), .timer_tick(tick),
      .counter_value(cnt), .counter_write(cw), .counter_top(ctop),
      .counter_bottom(1'b0), .waveform_mode_select(mode),
      .capture_input_pin(pin), .comparator_output(acmp), .irq_ack(ack),
      .irq_req(irq), .port_data(pd), .output_pin_direction_bit(dir),
      .compare_pin_o(po), .compare_pin_oe(poe));
   task automatic test_done;
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %h %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk) {addr, wd, reg_wr} <= {a, d, 1'b1};
      @(posedge ref_clk) reg_wr <= 0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk) {addr, reg_rd} <= {a, 1'b1};
      @(posedge ref_clk) reg_rd <= 0;
      @(negedge ref_clk) chk(rd, e);
   endtask
   task automatic wirq(input int i);
      for (int k = 0; k < 40 && irq[i] !== 1; k++) @(negedge ref_clk);
      chk(irq[i], 1'b1);
      if (irq[i] !== 1) test_done;
   endtask
   task automatic t_cmp;
      wr(tcc_pkg::ADDR_IRQ_EN, 8'h07);
      wr(tcc_pkg::ADDR_CMPA_HI, 8'h12);
      wr(tcc_pkg::ADDR_CMPA_LO, 8'h34);
      rdc(tcc_pkg::ADDR_CMPA_HI, 8'h12);
      @(posedge ref_clk) {cnt, tick} <= {16'h1234, 1'b1};
      wirq(1);
      @(posedge ref_clk) {cnt, tick} <= 17'h0;
      repeat (3) @(posedge ref_clk);
      ack <= 3'h2;
      @(posedge ref_clk) ack <= 0;
      @(negedge ref_clk) chk(irq[1], 1'b0);
      $display("t_cmp done");
   endtask
   task automatic t_block;
      @(posedge ref_clk) {cw, cnt} <= {1'b1, 16'h1234};
      @(posedge ref_clk) {cw, tick} <= 2'h1;
      @(posedge ref_clk) tick <= 0;
      @(negedge ref_clk) chk(irq[1], 1'b0);
      @(posedge ref_clk) tick <= 1;
      wirq(1);
      @(posedge ref_clk) tick <= 0;
      wr(tcc_pkg::ADDR_FLAGS, 8'h02);
      @(negedge ref_clk) chk(irq[1], 1'b0);
      $display("t_block done");
   endtask
   task automatic t_buf;
      @(posedge ref_clk) mode <= 4'h1;
      wr(tcc_pkg::ADDR_CMPB_HI, 8'h00);
      wr(tcc_pkg::ADDR_CMPB_LO, 8'h55);
      rdc(tcc_pkg::ADDR_CMPB_LO, 8'h55);
      @(posedge ref_clk) {cnt, tick} <= {16'h0055, 1'b1};
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) chk(irq[2], 1'b0);
      @(posedge ref_clk) ctop <= 1;
      @(posedge ref_clk) ctop <= 0;
      wirq(2);
      @(posedge ref_clk) {mode, tick} <= 5'h0;
      ack <= 3'h4;
      @(posedge ref_clk) ack <= 0;
      @(negedge ref_clk) chk(irq[2], 1'b0);
      $display("t_buf done");
   endtask
   task automatic t_cap;
      wr(tcc_pkg::ADDR_CTRL_B, 8'hc0);
      {cnt, lvl} <= {16'h0abc, 1'b1};
      wirq(0);
      rdc(tcc_pkg::ADDR_CAP_LO, 8'hbc);
      rdc(tcc_pkg::ADDR_CAP_HI, 8'h0a);
      @(posedge ref_clk) ack <= 3'h1;
      @(posedge ref_clk) ack <= 0;
      @(negedge ref_clk) chk(irq[0], 1'b0);
      wr(tcc_pkg::ADDR_CTRL_B, 8'h80);
      wr(tcc_pkg::ADDR_FLAGS, 8'h01);
      wr(tcc_pkg::ADDR_CTRL_B, 8'hc0);
      wr(tcc_pkg::ADDR_ACMP_CTRL, 8'h01);
      repeat (8) @(posedge ref_clk);
      wr(tcc_pkg::ADDR_FLAGS, 8'h01);
      @(negedge ref_clk) chk(irq[0], 1'b0);
      @(posedge ref_clk) {cnt, acmp} <= {16'h0def, 1'b1};
      wirq(0);
      rdc(tcc_pkg::ADDR_CAP_LO, 8'hef);
      wr(tcc_pkg::ADDR_FLAGS, 8'h01);
      $display("t_cap done");
   endtask
   task automatic t_force;
      dir <= 2'h1;
      wr(tcc_pkg::ADDR_FLAGS, 8'h07);
      wr(tcc_pkg::ADDR_CMP_CTRL, 8'hc8);
      repeat (3) @(posedge ref_clk);
      chk(po[0], 1'b1);
      chk(poe[0], 1'b1);
      chk(irq[1], 1'b0);
      $display("t_force done");
   endtask
   initial begin
      repeat (2) @(posedge ref_clk);
      sys_rst <= 0;
      t_cmp;
      t_block;
      t_buf;
      t_cap;
      t_force;
      test_done;
   end
endmodule // tcc_capcomp_tb
`default_nettype wire
